// file: pcsp_port.sv
// Purpose: Host serial port for game controllers and memory cards
// Assumes: Single 250 MHz clock, AXI4-Lite slave, peripheral pins asynchronous
// Notes: Bit-rate timer ticks at 33 MHz via a fractional enable
// Operation
// - Transfer starts while the transmit gate bit is set, or if it was set when data was written
// - Select bit drives chosen slot select low; slot bit picks slot
// - Received bytes are stored whenever active select is low
// - Force-receive stores next byte anyway; hardware clears it afterwards
// - Writing one to acknowledge bit clears parity and interrupt flags
// - Writing one to soft reset bit zeroes most port registers
// - Bits 8-9 pick receive threshold of 1, 2, 4 or 8 bytes
// - Bits 10-12 enable transmit, receive and ready-input interrupt sources
// - Timer reloads on reload write and at zero with reload times factor halved
// - Timer counts at 33 MHz and expires twice per serial bit
// - Default reload gives 44h timer ticks low and 44h high
// - Bit-rate timer always runs, transfer or not
// - Byte interrupt only follows a peripheral ready pulse
// - Interrupt flag cannot be cleared while ready input is low, except by soft reset
// - Receive buffer holds eight bytes with no overrun flag
// - Each byte is full duplex, sent and received together
// - Bits go least significant first
// - Peripheral changes data on falling edge; port samples on rising
// - No ready pulse within 100 us after a byte marks slot absent
// - Writing transmit data starts a byte when gated and ready
// - Rate factor codes 0,1,2,3 mean times 1,1,16,64
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
module pcsp_port
#(
   parameter int unsigned P_ACK_TIMEOUT_CYC = pcsp_pkg::ACK_TIMEOUT_CYC
)
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [31:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [31:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_serial_data_in,
   input wire logic i_ack_n,
   output pcsp_pkg::pcsp_link_out_t o_link
);
   import pcsp_pkg::*;

   typedef struct packed {
      logic aw_held;
      logic [31:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] ctrl;
      logic [15:0] mode;
      logic [15:0] reload;
      logic [7:0] frac;
      logic [20:0] timer;
      pcsp_phase_t phase;
      logic [2:0] bit_idx;
      logic [7:0] tx_byte;
      logic tx_pending;
      logic tx_latch;
      logic [7:0] shift_in;
      logic [7:0][7:0] fifo;
      logic [3:0] fifo_cnt;
      logic parity_err;
      logic irq;
      logic ack_wait;
      logic [15:0] ack_cnt;
      logic slot_absent;
      logic [1:0] dat_sync;
      logic [1:0] ack_sync;
      pcsp_link_out_t link;
   } pcsp_state_t;

   localparam pcsp_state_t ST_RESET = '{
      awready: 1'b1, wready: 1'b1, arready: 1'b1, reload: RELOAD_RESET,
      phase: PH_IDLE, dat_sync: 2'h3, ack_sync: 2'h3, link: LINK_IDLE, default: '0};

   pcsp_state_t st_reg;
   pcsp_state_t st_next;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic pcsp_reg_t reg_decode(input logic [31:0] addr);
      pcsp_reg_t sel;
      sel = RS_NONE;
      if (addr[31:2] == ADDR_DATA[31:2]) sel = RS_DATA;
      if (addr[31:2] == ADDR_STAT[31:2]) sel = RS_STAT;
      if (addr[31:2] == ADDR_MODE[31:2]) sel = RS_MODE;
      if (addr[31:2] == ADDR_CTRL[31:2]) sel = RS_CTRL;
      if (addr[31:2] == ADDR_BAUD[31:2]) sel = RS_BAUD;
      return sel;
   endfunction

   function automatic logic [20:0] half_load(input logic [15:0] r, input logic [1:0] f);
      logic [21:0] p;
      p = {6'h00, r};
      if (f == 2'h2) p = {2'h0, r, 4'h0};
      if (f == 2'h3) p = {r, 6'h00};
      return p[21:1];
   endfunction

   function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0] s);
      logic [15:0] v;
      v = old;
      if (s[0]) v[7:0] = d[7:0];
      if (s[1]) v[15:8] = d[15:8];
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   logic [8:0] facc;
   logic tick;
   logic expire;
   logic ack_low;
   logic do_write;
   logic byte_end;
   logic [3:0] rx_thr;
   logic [15:0] cval;
   pcsp_reg_t wsel;
   pcsp_reg_t rsel;

   always_comb
   begin
      st_next = st_reg;
      facc = {1'b0, st_reg.frac} + TICK_STEP;
      tick = 1'b0;
      expire = 1'b0;
      byte_end = 1'b0;
      cval = 16'h0000;
      ack_low = ~st_reg.ack_sync[1];
      wsel = reg_decode(st_reg.aw_addr);
      rsel = reg_decode(i_araddr);
      do_write = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
      rx_thr = 4'h1 << st_reg.ctrl[CTL_RX_MODE_LO +: 2];

      // Pin synchronisers
      st_next.dat_sync = {st_reg.dat_sync[0], i_serial_data_in};
      st_next.ack_sync = {st_reg.ack_sync[0], i_ack_n};

      // Free-running 33 MHz tick and bit-rate timer
      if (facc >= TICK_MOD)
      begin
         tick = 1'b1;
         st_next.frac = 8'(facc - TICK_MOD);
      end
      else
      begin
         st_next.frac = facc[7:0];
      end
      if (tick)
      begin
         if (st_reg.timer <= 21'h000001)
         begin
            expire = 1'b1;
            st_next.timer = half_load(st_reg.reload, st_reg.mode[1:0]);
         end
         else
         begin
            st_next.timer = st_reg.timer - 21'h000001;
         end
      end

      // Serial shifter, one half bit per timer expiry
      if (expire)
      begin
         unique case (st_reg.phase)
            PH_IDLE:
            begin
               if (st_reg.tx_pending && (st_reg.ctrl[CTL_TX_GATE] || st_reg.tx_latch))
               begin
                  st_next.phase = PH_LOW;
                  st_next.bit_idx = 3'h0;
                  st_next.tx_pending = 1'b0;
                  st_next.tx_latch = 1'b0;
                  st_next.slot_absent = 1'b0;
                  st_next.ack_wait = 1'b0;
                  st_next.link.serial_shift_clock = 1'b0;
                  st_next.link.serial_command_out = st_reg.tx_byte[0];
               end
            end
            PH_LOW:
            begin
               st_next.phase = PH_HIGH;
               st_next.link.serial_shift_clock = 1'b1;
               st_next.shift_in = {st_reg.dat_sync[1], st_reg.shift_in[7:1]};
            end
            PH_HIGH:
            begin
               if (st_reg.bit_idx == 3'h7)
               begin
                  st_next.phase = PH_IDLE;
                  byte_end = 1'b1;
               end
               else
               begin
                  st_next.phase = PH_LOW;
                  st_next.bit_idx = st_reg.bit_idx + 3'h1;
                  st_next.link.serial_shift_clock = 1'b0;
                  st_next.link.serial_command_out = st_reg.tx_byte[st_reg.bit_idx + 3'h1];
               end
            end
            default:
            begin
               st_next.phase = PH_IDLE;
               st_next.link.serial_shift_clock = 1'b1;
            end
         endcase
      end

      // Completed byte: store it, then wait for the ready pulse
      if (byte_end)
      begin
         if (st_reg.ctrl[CTL_SELECT] || st_reg.ctrl[CTL_FORCE_RX])
         begin
            if (st_reg.fifo_cnt < FIFO_DEPTH)
            begin
               st_next.fifo[st_reg.fifo_cnt[2:0]] = st_reg.shift_in;
               st_next.fifo_cnt = st_reg.fifo_cnt + 4'h1;
            end
         end
         st_next.ctrl[CTL_FORCE_RX] = 1'b0;
         st_next.ack_wait = 1'b1;
         st_next.ack_cnt = 16'h0000;
      end
      else if (st_reg.ack_wait)
      begin
         if (ack_low)
         begin
            st_next.ack_wait = 1'b0;
         end
         else if (32'(st_reg.ack_cnt) >= P_ACK_TIMEOUT_CYC - 1)
         begin
            st_next.ack_wait = 1'b0;
            st_next.slot_absent = 1'b1;
         end
         else
         begin
            st_next.ack_cnt = st_reg.ack_cnt + 16'h0001;
         end
      end

      // AXI read channel; a data read pops the oldest byte
      if (st_reg.rvalid && i_rready)
      begin
         st_next.rvalid = 1'b0;
      end
      if (st_reg.arready && i_arvalid)
      begin
         st_next.rvalid = 1'b1;
         st_next.rresp = RESP_OKAY;
         st_next.rdata = 32'h0000_0000;
         unique case (rsel)
            RS_DATA:
            begin
               st_next.rdata = st_reg.fifo[3:0];
               if (st_reg.fifo_cnt != 4'h0)
               begin
                  for (int i = 0; i < 7; i++)
                  begin
                     st_next.fifo[i] = st_next.fifo[i + 1];
                  end
                  st_next.fifo_cnt = st_next.fifo_cnt - 4'h1;
               end
            end
            RS_STAT:
            begin
               st_next.rdata = {st_reg.timer, st_reg.slot_absent, st_reg.irq, 1'b0, ack_low,
                  3'h0, st_reg.parity_err, (st_reg.phase == PH_IDLE) && !st_reg.tx_pending,
                  st_reg.fifo_cnt != 4'h0, !st_reg.tx_pending};
            end
            RS_MODE: st_next.rdata = {16'h0000, st_reg.mode};
            RS_CTRL: st_next.rdata = {16'h0000, st_reg.ctrl};
            RS_BAUD: st_next.rdata = {16'h0000, st_reg.reload};
            RS_NONE: st_next.rresp = RESP_SLVERR;
         endcase
      end
      st_next.arready = !st_next.rvalid;

      // AXI write channel
      if (st_reg.bvalid && i_bready)
      begin
         st_next.bvalid = 1'b0;
      end
      if (st_reg.awready && i_awvalid)
      begin
         st_next.aw_held = 1'b1;
         st_next.aw_addr = i_awaddr;
      end
      if (st_reg.wready && i_wvalid)
      begin
         st_next.w_held = 1'b1;
         st_next.w_data = i_wdata;
         st_next.w_strb = i_wstrb;
      end
      if (do_write)
      begin
         st_next.aw_held = 1'b0;
         st_next.w_held = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = (wsel == RS_NONE) ? RESP_SLVERR : RESP_OKAY;
         unique case (wsel)
            RS_DATA:
            begin
               if (st_reg.w_strb[0])
               begin
                  st_next.tx_byte = st_reg.w_data[7:0];
                  st_next.tx_pending = 1'b1;
                  st_next.tx_latch = st_reg.ctrl[CTL_TX_GATE];
               end
            end
            RS_MODE:
            begin
               st_next.mode = lane_merge(st_reg.mode, st_reg.w_data, st_reg.w_strb) & MODE_RW_MASK;
            end
            RS_BAUD:
            begin
               st_next.reload = lane_merge(st_reg.reload, st_reg.w_data, st_reg.w_strb);
               st_next.timer = half_load(st_next.reload, st_reg.mode[1:0]);
            end
            RS_CTRL:
            begin
               cval = lane_merge(st_reg.ctrl, st_reg.w_data, st_reg.w_strb);
               st_next.ctrl = cval & CTRL_RW_MASK;
               if (cval[CTL_ACK_CLEAR])
               begin
                  st_next.parity_err = 1'b0;
                  if (!ack_low)
                  begin
                     st_next.irq = 1'b0;
                  end
               end
               if (cval[CTL_SOFT_RESET])
               begin
                  st_next.ctrl = 16'h0000;
                  st_next.mode = 16'h0000;
                  st_next.fifo_cnt = 4'h0;
                  st_next.tx_pending = 1'b0;
                  st_next.tx_latch = 1'b0;
                  st_next.phase = PH_IDLE;
                  st_next.link.serial_shift_clock = 1'b1;
                  st_next.parity_err = 1'b0;
                  st_next.irq = 1'b0;
                  st_next.ack_wait = 1'b0;
                  st_next.slot_absent = 1'b0;
               end
            end
            default:
            begin
            end
         endcase
      end
      st_next.awready = !st_next.aw_held;
      st_next.wready = !st_next.w_held;

      // Interrupt sources; a set wins over a clear in the same cycle
      if ((st_reg.ctrl[CTL_ACK_IRQ_EN] && ack_low)
          || (st_reg.ctrl[CTL_TX_IRQ_EN] && !st_reg.tx_pending)
          || (st_reg.ctrl[CTL_RX_IRQ_EN] && st_reg.fifo_cnt >= rx_thr))
      begin
         st_next.irq = 1'b1;
      end

      // Slot selects follow the control register
      st_next.link.slot_one_select_n = !(st_next.ctrl[CTL_SELECT] && !st_next.ctrl[CTL_SLOT]);
      st_next.link.slot_two_select_n = !(st_next.ctrl[CTL_SELECT] && st_next.ctrl[CTL_SLOT]);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         st_reg <= ST_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign o_awready = st_reg.awready;
   assign o_wready = st_reg.wready;
   assign o_bvalid = st_reg.bvalid;
   assign o_bresp = st_reg.bresp;
   assign o_arready = st_reg.arready;
   assign o_rvalid = st_reg.rvalid;
   assign o_rdata = st_reg.rdata;
   assign o_rresp = st_reg.rresp;
   assign o_link = st_reg.link;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_last_half;
      expire && st_reg.phase == PH_HIGH && st_reg.bit_idx == 3'h7;
   endsequence

   sequence s_start;
      expire && st_reg.phase == PH_IDLE && st_reg.tx_pending
         && (st_reg.ctrl[CTL_TX_GATE] || st_reg.tx_latch);
   endsequence

   a_gate_blocks: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_reg.phase == PH_IDLE && !st_reg.ctrl[CTL_TX_GATE] && !st_reg.tx_latch
      && !do_write |=> st_reg.phase == PH_IDLE)
      else $error("transfer started without transmit gate");

   a_select_slot: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_reg.ctrl[CTL_SELECT] && !st_reg.ctrl[CTL_SLOT] && !do_write
      |=> !o_link.slot_one_select_n && o_link.slot_two_select_n)
      else $error("slot one select not driven low");

   a_force_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_last_half and (!do_write) |=> !st_reg.ctrl[CTL_FORCE_RX])
      else $error("force receive not cleared after transfer");

   a_irq_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_reg.irq && !st_reg.ack_sync[1] && !(do_write && cval[CTL_SOFT_RESET]) |=> st_reg.irq)
      else $error("interrupt cleared while ready input low");

   a_reload_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
      do_write && wsel == RS_BAUD && st_reg.w_strb[1:0] == 2'h3
      |=> st_reg.timer == half_load(st_reg.reload, st_reg.mode[1:0]))
      else $error("timer not reloaded on reload write");

   a_default_rate: assert property (@(posedge i_clk) disable iff (!i_nrst)
      tick && st_reg.timer <= 21'h000001 && st_reg.reload == RELOAD_RESET
      && st_reg.mode[1:0] <= 2'h1 && !do_write |=> st_reg.timer == 21'h000044)
      else $error("default half bit is not 44h ticks");

   a_timer_runs: assert property (@(posedge i_clk) disable iff (!i_nrst)
      tick && st_reg.timer > 21'h000001 && !do_write
      |=> st_reg.timer == $past(st_reg.timer) - 21'h000001)
      else $error("bit-rate timer stalled");

   a_fifo_bound: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_reg.fifo_cnt <= FIFO_DEPTH)
      else $error("receive buffer beyond eight bytes");

   a_lsb_first: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_start and (!do_write) |=> !o_link.serial_shift_clock
      && o_link.serial_command_out == $past(st_reg.tx_byte[0]))
      else $error("first bit out is not the lsb");

   a_clock_low: assert property (@(posedge i_clk) disable iff (!i_nrst)
      st_reg.phase == PH_LOW |-> !o_link.serial_shift_clock)
      else $error("shift clock high in low phase");

endmodule

// file: pcsp_pkg.sv
// Purpose: Shared constants and types for the pad and card serial port
// Assumes: 250 MHz system clock, AXI4-Lite register access
// Notes: Byte address of a register is four times its index
package pcsp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices and byte addresses
   localparam logic [31:0] IDX_DATA = 32'h1F80_1040;
   localparam logic [31:0] IDX_STAT = 32'h1F80_1044;
   localparam logic [31:0] IDX_MODE = 32'h1F80_1048;
   localparam logic [31:0] IDX_CTRL = 32'h1F80_104A;
   localparam logic [31:0] IDX_BAUD = 32'h1F80_104E;
   localparam logic [31:0] ADDR_DATA = IDX_DATA << 2;
   localparam logic [31:0] ADDR_STAT = IDX_STAT << 2;
   localparam logic [31:0] ADDR_MODE = IDX_MODE << 2;
   localparam logic [31:0] ADDR_CTRL = IDX_CTRL << 2;
   localparam logic [31:0] ADDR_BAUD = IDX_BAUD << 2;

   ////////////////////////////////////////////////////////////////////////////
   // Control field positions
   localparam int CTL_TX_GATE = 0;
   localparam int CTL_SELECT = 1;
   localparam int CTL_FORCE_RX = 2;
   localparam int CTL_ACK_CLEAR = 4;
   localparam int CTL_SOFT_RESET = 6;
   localparam int CTL_RX_MODE_LO = 8;
   localparam int CTL_TX_IRQ_EN = 10;
   localparam int CTL_RX_IRQ_EN = 11;
   localparam int CTL_ACK_IRQ_EN = 12;
   localparam int CTL_SLOT = 13;
   localparam logic [15:0] CTRL_RW_MASK = 16'h3F2F;
   localparam logic [15:0] MODE_RW_MASK = 16'h013F;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and timing
   localparam logic [15:0] RELOAD_RESET = 16'h0088;
   localparam logic [8:0] TICK_STEP = 9'h021;
   localparam logic [8:0] TICK_MOD = 9'h0FA;
   localparam int CLK_MHZ = 250;
   localparam int ACK_TIMEOUT_US = 100;
   localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_US * CLK_MHZ;
   localparam logic [3:0] FIFO_DEPTH = 4'h8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {
      PH_IDLE = 2'h0,
      PH_LOW = 2'h1,
      PH_HIGH = 2'h3
   } pcsp_phase_t;

   typedef enum logic [2:0] {
      RS_NONE = 3'h0,
      RS_DATA = 3'h1,
      RS_STAT = 3'h2,
      RS_MODE = 3'h3,
      RS_CTRL = 3'h4,
      RS_BAUD = 3'h5
   } pcsp_reg_t;

   typedef struct packed {
      logic serial_shift_clock;
      logic serial_command_out;
      logic slot_one_select_n;
      logic slot_two_select_n;
   } pcsp_link_out_t;

   localparam pcsp_link_out_t LINK_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1};

endpackage

// file: pcsp_peripheral.sv
// Purpose: Controller model on slot one of the serial port
// Assumes: Data and ready lines are pulled up when released
// Notes: Ready pulse can be withheld to model an empty slot
`timescale 1ns/10ps
module pcsp_peripheral
import pcsp_pkg::*;
(
   input pcsp_pkg::pcsp_link_out_t i_link,
   input wire logic [7:0] i_resp,
   input wire logic i_ack_en,
   output logic o_data,
   output logic o_ack_n,
   output logic [7:0] o_cmd
);
   ////////////////////////////////////////
   int bitn = 0;
   logic drv = 1'b1;
   initial o_ack_n = 1'b1;
   // Pull-up level while not selected
   assign o_data = i_link.slot_one_select_n ? 1'b1 : drv;
   always @(negedge i_link.serial_shift_clock)
   begin
      if (!i_link.slot_one_select_n)
         drv = i_resp[bitn];
   end
   always @(posedge i_link.serial_shift_clock)
   begin
      if (!i_link.slot_one_select_n)
      begin
         o_cmd[bitn] = i_link.serial_command_out;
         bitn = bitn + 1;
      end
      if (bitn == 8)
      begin
         bitn = 0;
         if (i_ack_en)
         begin
            #1000 o_ack_n = 1'b0;
            #2400 o_ack_n = 1'b1;
         end
      end
   end
endmodule

// file: pcsp_port_test.sv
// Purpose: Register-level test of the serial port
// Assumes: Partner model on slot one
// Notes: Short reload and ready timeout keep the run brief
`timescale 1ns/10ps
module pcsp_port_test;
import pcsp_pkg::*;
   ////////////////////////////////////////
   logic i_clk = 0, i_nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rd_data, s1;
   logic [3:0] wstrb = 0;
   logic [1:0] rd_resp, wr_resp, bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, sdata, ack_n;
   logic [31:0] rdata;
   logic [7:0] cmd;
   pcsp_link_out_t link;
   int n_errors = 0, cmp_count = 0, lo, k;
   initial forever #2 i_clk = ~i_clk;
   pcsp_port #(.P_ACK_TIMEOUT_CYC(400)) pcsp_port_inst (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
      .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
      .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
      .i_rready(rready), .i_serial_data_in(sdata), .i_ack_n(ack_n), .o_link(link));
   pcsp_peripheral pcsp_peripheral_inst (.i_link(link), .i_resp(8'hA5), .i_ack_en(1'b1),
      .o_data(sdata), .o_ack_n(ack_n), .o_cmd(cmd));
   ////////////////////////////////////////
   task end_sim;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         n_errors++;
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      int t = 0;
      @(posedge i_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge i_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         t++;
      end
      while (bvalid !== 1'b1 && t < 100);
      wr_resp = bresp;
      bready <= 1'b0;
      if (bvalid !== 1'b1) chk("write timeout", 1, 0);
      if (bvalid !== 1'b1) end_sim;
   endtask
   task automatic rd(input logic [31:0] a);
      int t = 0;
      @(posedge i_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge i_clk);
         if (arready) arvalid <= 1'b0;
         t++;
      end
      while (rvalid !== 1'b1 && t < 100);
      rd_data = rdata;
      rd_resp = rresp;
      rready <= 1'b0;
      if (rvalid !== 1'b1) chk("read timeout", 1, 0);
      if (rvalid !== 1'b1) end_sim;
   endtask
   task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
      int t = 0;
      do
      begin
         rd(ADDR_STAT);
         t++;
      end
      while ((rd_data & m) !== v && t < 2000);
      chk("status wait", v, rd_data & m);
      if ((rd_data & m) !== v) end_sim;
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge i_clk);
      i_nrst <= 1'b1;
      rd(ADDR_BAUD);
      chk("reload reset", 32'h0088, rd_data);
      rd(ADDR_CTRL);
      chk("control reset", 32'h0, rd_data);
      rd(32'h0000_0010);
      chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, rd_resp});
      s1 = rd_data;
      rd(ADDR_STAT);
      s1 = rd_data;
      repeat (16) @(posedge i_clk);
      rd(ADDR_STAT);
      chk("timer running", 1, s1[31:11] != rd_data[31:11]);
      wr(ADDR_MODE, 32'h0002);
      wr(ADDR_BAUD, 32'h0010);
      rd(ADDR_STAT);
      chk("x16 reload", 1, rd_data[31:11] inside {[21'h7F:21'h80]});
      wr(ADDR_MODE, 32'h0001);
      wr(ADDR_BAUD, 32'h0010);
      wr(ADDR_CTRL, 32'h0002);
      chk("slot one select", 0, link.slot_one_select_n);
      chk("slot two select", 1, link.slot_two_select_n);
      wr(ADDR_DATA, 32'h0000_0001);
      repeat (300) @(posedge i_clk);
      chk("gated clock", 1, link.serial_shift_clock);
      wr(ADDR_CTRL, 32'h1003);
      for (k = 0; k < 400 && link.serial_shift_clock; k++) @(posedge i_clk);
      for (k = 0; k < 400 && !link.serial_shift_clock; k++) @(posedge i_clk);
      for (lo = 0; lo < 400 && link.serial_shift_clock; lo++) @(posedge i_clk);
      chk("half period", 1, lo inside {[59:62]});
      wait_st(32'h4, 32'h4);
      chk("command byte", 32'h01, {24'h0, cmd});
      wait_st(32'h80, 32'h80);
      rd(ADDR_STAT);
      chk("irq after ready", 1, rd_data[9]);
      chk("slot present", 0, rd_data[10]);
      wr(ADDR_CTRL, 32'h0013);
      rd(ADDR_STAT);
      chk("clear while low", 1, rd_data[9]);
      wait_st(32'h80, 32'h0);
      wr(ADDR_CTRL, 32'h1013);
      rd(ADDR_STAT);
      chk("irq cleared", 0, rd_data[9]);
      chk("select held", 0, link.slot_one_select_n);
      rd(ADDR_DATA);
      chk("rx byte", 32'hA5, {24'h0, rd_data[7:0]});
      wr(ADDR_CTRL, 32'h1005);
      wr(ADDR_DATA, 32'h0000_005A);
      wait_st(32'h4, 32'h4);
      rd(ADDR_CTRL);
      chk("force bit cleared", 0, rd_data[2]);
      wr(ADDR_CTRL, 32'h0900);
      rd(ADDR_STAT);
      chk("below threshold", 0, rd_data[9]);
      wr(ADDR_CTRL, 32'h0800);
      rd(ADDR_STAT);
      chk("threshold irq", 1, rd_data[9]);
      rd(ADDR_DATA);
      chk("forced rx byte", 32'hFF, {24'h0, rd_data[7:0]});
      wr(ADDR_CTRL, 32'h1010);
      wait_st(32'h400, 32'h400);
      chk("no irq without ready", 0, rd_data[9]);
      wr(ADDR_CTRL, 32'h0040);
      rd(ADDR_CTRL);
      chk("soft reset control", 0, rd_data);
      rd(ADDR_MODE);
      chk("soft reset mode", 0, rd_data);
      wr(ADDR_CTRL, 32'h0400);
      rd(ADDR_STAT);
      chk("tx ready irq", 1, rd_data[9]);
      wr(32'h0000_0010, 32'h1);
      chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, wr_resp});
      end_sim;
   end
endmodule
